// >>> src/bwalu_core.sv
// byte alu datapath with status flags, word immediate ops and multiplier
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
// Summary of operation
// - add registers, optional carry, all six flags
// - subtract register, optional borrow, six flags
// - subtract constant, optional borrow, six flags
// - word pair plus constant, two clocks
// - word pair minus constant, two clocks
// - and with register or constant, z n v
// - or and xor update z n v
// - invert sets carry; negate adds half carry
// - set or clear bits by mask
// - plus or minus one, carry untouched
// - test, clear, set all ones
// - multiplies fill product pair in two clocks
module bwalu_core
  import bwalu_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              op_valid,
  input  wire bwalu_op_e         op_code,
  input  wire logic [7:0]        dst_lo,
  input  wire logic [7:0]        dst_hi,
  input  wire logic [7:0]        source_reg,
  input  wire logic [7:0]        imm,
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic                   op_ready_q,
  output logic                   res_valid_q,
  output logic [7:0]             res_lo_q,
  output logic [7:0]             res_hi_q,
  output logic                   res_wide_q,
  output logic                   res_pair_q,
  output logic [7:0]             flags_q,
  output logic [7:0]             reg_rdata_q
);

  // result of a byte op: {half carry, carry, overflow, byte}
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
    logic [4:0] lo;
    logic [8:0] s;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    s  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {lo[4], s[8], (a[7] == b[7]) && (s[7] != a[7]), s[7:0]};
  endfunction : add8

  function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                       input logic bin);
    logic [4:0] lo;
    logic [8:0] s;
    lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
    s  = {1'b0, a} - {1'b0, b} - {8'h00, bin};
    return {lo[4], s[8], (a[7] != b[7]) && (s[7] != a[7]), s[7:0]};
  endfunction : sub8

  // zero, negative, overflow and the sign that follows from them
  function automatic logic [7:0] znvs(input logic [7:0] f, input logic [7:0] r,
                                      input logic v);
    logic [7:0] o;
    o        = f;
    o[FLG_Z] = (r == ALL_ZERO);
    o[FLG_N] = r[7];
    o[FLG_V] = v;
    o[FLG_S] = r[7] ^ v;
    return o;
  endfunction : znvs

  logic       rst_meta_q;
  logic       rst_n_q;
  bwalu_st_e  state_q;
  logic       second_mul_q;
  logic       word_sub_q;
  logic [7:0] word_lo_q;
  logic [7:0] word_hi_q;
  logic [7:0] word_k_q;
  logic [10:0] ar;
  logic [7:0] alu_flags;
  logic       upd_znv;
  logic       upd_c;
  logic       upd_h;
  logic       two_cycle;
  logic       accept;
  logic       flag_wr;
  logic [15:0] word_in;
  logic [16:0] word_sum;
  logic [15:0] word_res;
  logic [7:0]  word_flags;
  logic [7:0]  mul_flags;
  logic [15:0] product;
  bwalu_mul_e  mul_mode;

  // asynchronous assert, synchronised release
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  assign accept  = op_valid && op_ready_q;
  assign flag_wr = reg_wr && (reg_addr == REG_FLAGS);

  always_comb begin
    ar        = {3'b000, dst_lo};
    upd_znv   = 1'b1;
    upd_c     = 1'b0;
    upd_h     = 1'b0;
    two_cycle = 1'b0;
    unique case (op_code)
      OP_ADD, OP_ADD_CARRY: begin
        ar    = add8(dst_lo, source_reg, (op_code == OP_ADD_CARRY) && flags_q[FLG_C]);
        upd_c = 1'b1;
        upd_h = 1'b1;
      end
      OP_SUB, OP_MINUS_REGISTER_BORROW: begin
        ar    = sub8(dst_lo, source_reg,
                     (op_code == OP_MINUS_REGISTER_BORROW) && flags_q[FLG_C]);
        upd_c = 1'b1;
        upd_h = 1'b1;
      end
      OP_MINUS_IMMEDIATE, OP_MINUS_IMMEDIATE_BORROW: begin
        ar    = sub8(dst_lo, imm, (op_code == OP_MINUS_IMMEDIATE_BORROW) && flags_q[FLG_C]);
        upd_c = 1'b1;
        upd_h = 1'b1;
      end
      OP_AND:                   ar = {3'b000, dst_lo & source_reg};
      OP_CONJUNCTION_IMMEDIATE: ar = {3'b000, dst_lo & imm};
      OP_OR:                    ar = {3'b000, dst_lo | source_reg};
      OP_DISJUNCTION_IMMEDIATE: ar = {3'b000, dst_lo | imm};
      OP_EXCLUSIVE_DISJUNCTION: ar = {3'b000, dst_lo ^ source_reg};
      OP_INVERT_ALL_BITS: begin
        ar    = {1'b0, 1'b1, 1'b0, ALL_ONES - dst_lo};
        upd_c = 1'b1;
      end
      OP_TWOS_MINUS: begin
        ar    = sub8(ALL_ZERO, dst_lo, 1'b0);
        upd_c = 1'b1;
        upd_h = 1'b1;
      end
      OP_BIT_SET_MASK:   ar = {3'b000, dst_lo | imm};
      OP_BIT_CLEAR_MASK: ar = {3'b000, dst_lo & (ALL_ONES - imm)};
      OP_PLUS_ONE:  ar = add8(dst_lo, ONE_BYTE, 1'b0);
      OP_MINUS_ONE: ar = sub8(dst_lo, ONE_BYTE, 1'b0);
      OP_SELF_AND_CHECK:    ar = {3'b000, dst_lo & dst_lo};
      OP_ZERO_REGISTER:     ar = {3'b000, dst_lo ^ dst_lo};
      OP_ALL_ONES_REGISTER: begin
        ar      = {3'b000, ALL_ONES};
        upd_znv = 1'b0;
      end
      OP_WORD_ADD_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE,
      OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED_SIGN: begin
        upd_znv   = 1'b0;
        two_cycle = 1'b1;
      end
      default: upd_znv = 1'b0;
    endcase
  end

  // half carry from nibble, sign from n and v
  always_comb begin
    alu_flags = flags_q;
    if (upd_znv) alu_flags = znvs(flags_q, ar[7:0], ar[8]);
    if (upd_c) alu_flags[FLG_C] = ar[9];
    if (upd_h) alu_flags[FLG_H] = ar[10];
  end

  always_comb begin
    word_in    = {word_hi_q, word_lo_q};
    word_sum   = word_sub_q ? ({1'b0, word_in} - {9'h000, word_k_q})
                            : ({1'b0, word_in} + {9'h000, word_k_q});
    word_res   = word_sum[15:0];
    word_flags = flags_q;
    word_flags[FLG_Z] = (word_res == 16'h0000);
    word_flags[FLG_N] = word_res[15];
    word_flags[FLG_V] = word_sub_q ? (word_hi_q[7] & ~word_res[15])
                                   : (~word_hi_q[7] & word_res[15]);
    word_flags[FLG_C] = word_sub_q ? (word_res[15] & ~word_hi_q[7])
                                   : (~word_res[15] & word_hi_q[7]);
    word_flags[FLG_S] = word_flags[FLG_N] ^ word_flags[FLG_V];
  end

  // multiply carry from product bit 15
  always_comb begin
    mul_flags        = flags_q;
    mul_flags[FLG_Z] = (product == 16'h0000);
    mul_flags[FLG_C] = product[15];
  end

  always_comb begin
    unique case (op_code)
      OP_PRODUCT_SIGNED:     mul_mode = MUL_SIGNED;
      OP_PRODUCT_MIXED_SIGN: mul_mode = MUL_MIXED;
      default:               mul_mode = MUL_UNSIGNED;
    endcase
  end

  bwalu_mult #(
    .WIDTH (DATA_W)
  ) u_mult (
    .core_clk  (core_clk),
    .rst_n     (rst_n_q),
    .load      (accept && two_cycle),
    .mode      (mul_mode),
    .op_a      (dst_lo),
    .op_b      (source_reg),
    .product_q (product)
  );

  // sequencing: two clock ops hold off the next request for one cycle
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q      <= ST_IDLE;
      op_ready_q   <= 1'b0;
      second_mul_q <= 1'b0;
      word_sub_q   <= 1'b0;
      word_lo_q    <= RES_RESET;
      word_hi_q    <= RES_RESET;
      word_k_q     <= RES_RESET;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          op_ready_q <= 1'b1;
          if (accept && two_cycle) begin
            state_q      <= ST_SECOND;
            op_ready_q   <= 1'b0;
            second_mul_q <= (op_code != OP_WORD_ADD_IMMEDIATE) &&
                            (op_code != OP_WORD_MINUS_IMMEDIATE);
            word_sub_q   <= (op_code == OP_WORD_MINUS_IMMEDIATE);
            word_lo_q    <= dst_lo;
            word_hi_q    <= dst_hi;
            word_k_q     <= imm;
          end
        end
        ST_SECOND: begin
          state_q    <= ST_IDLE;
          op_ready_q <= 1'b1;
        end
      endcase
    end
  end

  // result registers
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      res_valid_q <= 1'b0;
      res_lo_q    <= RES_RESET;
      res_hi_q    <= RES_RESET;
      res_wide_q  <= 1'b0;
      res_pair_q  <= 1'b0;
    end else begin
      res_valid_q <= 1'b0;
      if (state_q == ST_SECOND) begin
        res_valid_q <= 1'b1;
        res_wide_q  <= 1'b1;
        res_pair_q  <= second_mul_q;
        res_lo_q    <= second_mul_q ? product[7:0] : word_res[7:0];
        res_hi_q    <= second_mul_q ? product[15:8] : word_res[15:8];
      end else if (accept && !two_cycle) begin
        res_valid_q <= 1'b1;
        res_wide_q  <= 1'b0;
        res_pair_q  <= 1'b0;
        res_lo_q    <= ar[7:0];
        res_hi_q    <= RES_RESET;
      end
    end
  end

  // flags; a software write in the same cycle takes precedence
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flags_q <= FLAGS_RESET;
    end else if (flag_wr) begin
      flags_q <= reg_wdata;
    end else if (state_q == ST_SECOND) begin
      flags_q <= second_mul_q ? mul_flags : word_flags;
    end else if (accept && !two_cycle) begin
      flags_q <= alu_flags;
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata_q <= ALL_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_FLAGS:  reg_rdata_q <= flags_q;
        REG_RES_LO: reg_rdata_q <= res_lo_q;
        REG_RES_HI: reg_rdata_q <= res_hi_q;
        default:    reg_rdata_q <= ALL_ZERO;
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_q);

  logic take;
  assign take = accept && !reg_wr;

  a_add_sum: assert property (take && op_code == OP_ADD |=>
    res_valid_q && res_lo_q == 8'($past(dst_lo) + $past(source_reg)))
    else $error("add result wrong");
  a_sub_carry: assert property (take && op_code == OP_SUB |=>
    flags_q[FLG_C] == ($past(source_reg) > $past(dst_lo)))
    else $error("subtract borrow wrong");
  a_imm_sub_zero: assert property (take && op_code == OP_MINUS_IMMEDIATE |=>
    flags_q[FLG_Z] == ($past(dst_lo) == $past(imm)))
    else $error("immediate subtract zero wrong");
  a_word_two: assert property (take && op_code == OP_WORD_ADD_IMMEDIATE |=>
    !res_valid_q && !op_ready_q ##1 res_valid_q && res_wide_q && !res_pair_q)
    else $error("word add timing wrong");
  a_word_sub: assert property (take && op_code == OP_WORD_MINUS_IMMEDIATE |->
    ##2 {res_hi_q, res_lo_q} == 16'({$past(dst_hi, 2), $past(dst_lo, 2)} - $past(imm, 2)))
    else $error("word subtract result wrong");
  a_and_vclear: assert property (take && op_code == OP_AND |=>
    !flags_q[FLG_V] && $stable(flags_q[FLG_C]) && $stable(flags_q[FLG_H]))
    else $error("and flags wrong");
  a_xor_value: assert property (take && op_code == OP_EXCLUSIVE_DISJUNCTION |=>
    res_lo_q == ($past(dst_lo) ^ $past(source_reg)) && !flags_q[FLG_V])
    else $error("xor result wrong");
  a_inv_carry: assert property (take && op_code == OP_INVERT_ALL_BITS |=>
    flags_q[FLG_C] && res_lo_q == ~$past(dst_lo))
    else $error("invert result wrong");
  a_clear_mask: assert property (take && op_code == OP_BIT_CLEAR_MASK |=>
    res_lo_q == ($past(dst_lo) & ~$past(imm)))
    else $error("clear mask wrong");
  a_inc_carry: assert property (take && op_code == OP_PLUS_ONE |=>
    $stable(flags_q[FLG_C]) && flags_q[FLG_V] == ($past(dst_lo) == 8'h7f))
    else $error("increment flags wrong");
  a_setall_flags: assert property (take && op_code == OP_ALL_ONES_REGISTER |=>
    res_lo_q == ALL_ONES && $stable(flags_q))
    else $error("set all touched flags");
  a_mul_pair: assert property (take && op_code == OP_PRODUCT_UNSIGNED |->
    ##2 res_pair_q && {res_hi_q, res_lo_q} == 16'($past(dst_lo, 2) * $past(source_reg, 2))
    && flags_q[FLG_C] == res_hi_q[7])
    else $error("unsigned product wrong");
  a_sign_xor: assert property (take && op_code == OP_ADD_CARRY |=>
    flags_q[FLG_S] == (flags_q[FLG_N] ^ flags_q[FLG_V]))
    else $error("sign flag wrong");

  c_add_op:  cover property (take && op_code == OP_ADD ##1 res_valid_q);
  c_word_op: cover property (take && op_code == OP_WORD_MINUS_IMMEDIATE ##2 res_valid_q);
  c_mul_minus: cover property (take && op_code == OP_PRODUCT_SIGNED ##2 res_hi_q[7]);
  c_flag_rd: cover property (reg_rd && reg_addr == REG_FLAGS);

endmodule : bwalu_core

// >>> src/bwalu_mult.sv
// registered 8x8 multiplier, unsigned, signed and mixed sign
`timescale 1ns/10ps
module bwalu_mult
  import bwalu_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 load,
  input  wire bwalu_mul_e           mode,
  input  wire logic [WIDTH-1:0]     op_a,
  input  wire logic [WIDTH-1:0]     op_b,
  output logic      [2*WIDTH-1:0]   product_q
);

  initial begin
    if (WIDTH < 2 || WIDTH > 32) $error("bwalu_mult: unsupported width");
  end

  logic                      ext_a;
  logic                      ext_b;
  logic signed [2*WIDTH+1:0] full;

  // one extra bit per operand lets a single signed multiplier serve all modes
  always_comb begin
    ext_a = (mode != MUL_UNSIGNED) & op_a[WIDTH-1];
    ext_b = (mode == MUL_SIGNED) & op_b[WIDTH-1];
    full  = $signed({ext_a, op_a}) * $signed({ext_b, op_b});
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      product_q <= '0;
    end else if (load) begin
      product_q <= full[2*WIDTH-1:0];
    end
  end

endmodule : bwalu_mult

// >>> src/bwalu_pkg.sv
// constants and types shared by the byte alu datapath
package bwalu_pkg;

  localparam int unsigned DATA_W = 8;

  // flag positions inside the status byte
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;

  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] RES_RESET   = 8'h00;
  localparam logic [7:0] ALL_ONES    = 8'hff;
  localparam logic [7:0] ALL_ZERO    = 8'h00;
  localparam logic [7:0] ONE_BYTE    = 8'h01;

  // register port offsets
  localparam int unsigned  REG_AW     = 2;
  localparam logic [1:0]   REG_FLAGS  = 2'h0;
  localparam logic [1:0]   REG_RES_LO = 2'h1;
  localparam logic [1:0]   REG_RES_HI = 2'h2;

  typedef enum logic [4:0] {
    OP_ADD,
    OP_ADD_CARRY,
    OP_SUB,
    OP_MINUS_REGISTER_BORROW,
    OP_MINUS_IMMEDIATE,
    OP_MINUS_IMMEDIATE_BORROW,
    OP_WORD_ADD_IMMEDIATE,
    OP_WORD_MINUS_IMMEDIATE,
    OP_AND,
    OP_CONJUNCTION_IMMEDIATE,
    OP_OR,
    OP_DISJUNCTION_IMMEDIATE,
    OP_EXCLUSIVE_DISJUNCTION,
    OP_INVERT_ALL_BITS,
    OP_TWOS_MINUS,
    OP_BIT_SET_MASK,
    OP_BIT_CLEAR_MASK,
    OP_PLUS_ONE,
    OP_MINUS_ONE,
    OP_SELF_AND_CHECK,
    OP_ZERO_REGISTER,
    OP_ALL_ONES_REGISTER,
    OP_PRODUCT_UNSIGNED,
    OP_PRODUCT_SIGNED,
    OP_PRODUCT_MIXED_SIGN
  } bwalu_op_e;

  typedef enum logic [1:0] {
    MUL_UNSIGNED,
    MUL_SIGNED,
    MUL_MIXED
  } bwalu_mul_e;

  typedef enum logic {
    ST_IDLE,
    ST_SECOND
  } bwalu_st_e;

endpackage : bwalu_pkg

// >>> verif/bwalu_core_tb_top.sv
// self-checking bench for the byte alu datapath
`timescale 1ns/10ps
module bwalu_core_tb_top;
  import bwalu_pkg::*;
  logic       core_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       op_valid, op_ready_q, res_valid_q, res_wide_q, res_pair_q;
  bwalu_op_e  op_code;
  logic [7:0] dst_lo, dst_hi, source_reg, imm;
  logic [7:0] res_lo_q, res_hi_q, flags_q, reg_rdata_q;
  int         mismatches = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  always #2 core_clk = ~core_clk;

  bwalu_core u_bwalu_core (.core_clk(core_clk), .reset_n(reset_n), .op_valid(op_valid),
    .op_code(op_code), .dst_lo(dst_lo), .dst_hi(dst_hi), .source_reg(source_reg),
    .imm(imm), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .op_ready_q(op_ready_q), .res_valid_q(res_valid_q),
    .res_lo_q(res_lo_q), .res_hi_q(res_hi_q), .res_wide_q(res_wide_q),
    .res_pair_q(res_pair_q), .flags_q(flags_q), .reg_rdata_q(reg_rdata_q));

  bwalu_dec_model u_bwalu_dec_model (.core_clk(core_clk), .op_ready_q(op_ready_q),
    .op_valid(op_valid), .op_code(op_code), .dst_lo(dst_lo), .dst_hi(dst_hi),
    .source_reg(source_reg), .imm(imm));

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // hang guard, well above the roughly 150 cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr_t(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_wr_t

  task automatic reg_rd_chk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata_q, exp);
  endtask : reg_rd_chk

  // flags preset by software, then one operation, latency and result judged
  task automatic run(input bwalu_op_e op, input logic [15:0] d, input logic [7:0] s, k,
                     input logic [7:0] pre, input logic [15:0] r, input logic [7:0] f);
    bit   tk;
    int   lat = 0;
    logic pair, wide;
    pair = (op >= OP_PRODUCT_UNSIGNED);
    wide = pair || (op == OP_WORD_ADD_IMMEDIATE) || (op == OP_WORD_MINUS_IMMEDIATE);
    reg_wr_t(REG_FLAGS, pre);
    u_bwalu_dec_model.issue(op, d[7:0], d[15:8], s, k, tk);
    do begin
      @(negedge core_clk);
      lat++;
    end while (res_valid_q !== 1'b1 && lat < 6);
    chk({tk, lat[3:0]}, {1'b1, (wide ? 4'h2 : 4'h1)});
    chk({res_pair_q, res_wide_q, res_hi_q, res_lo_q}, {pair, wide, r});
    chk(flags_q, f);
  endtask : run

  task automatic t_reset();
    int n = 0;
    while (op_ready_q !== 1'b1 && n < 10) begin
      n++;
      @(posedge core_clk);
    end
    reg_rd_chk(REG_FLAGS, FLAGS_RESET);
    reg_rd_chk(REG_RES_LO, RES_RESET);
    reg_rd_chk(REG_RES_HI, RES_RESET);
    $display("reset test done");
  endtask : t_reset

  task automatic t_arith();
    run(OP_ADD, 16'h000f, 8'h01, 8'h00, 8'h00, 16'h0010, 8'h20);
    run(OP_ADD, 16'h0080, 8'h80, 8'h00, 8'h00, 16'h0000, 8'h1b);
    run(OP_ADD_CARRY, 16'h007f, 8'h00, 8'h00, 8'h01, 16'h0080, 8'h2c);
    run(OP_ADD_CARRY, 16'h007f, 8'h00, 8'h00, 8'h00, 16'h007f, 8'h00);
    run(OP_SUB, 16'h0010, 8'h01, 8'h00, 8'h00, 16'h000f, 8'h20);
    run(OP_SUB, 16'h0000, 8'h01, 8'h00, 8'h00, 16'h00ff, 8'h35);
    run(OP_MINUS_REGISTER_BORROW, 16'h0005, 8'h04, 8'h00, 8'h01, 16'h0000, 8'h02);
    run(OP_MINUS_IMMEDIATE, 16'h0080, 8'h00, 8'h01, 8'h00, 16'h007f, 8'h38);
    run(OP_MINUS_IMMEDIATE_BORROW, 16'h0000, 8'h00, 8'h00, 8'h01, 16'h00ff, 8'h35);
    $display("arith test done");
  endtask : t_arith

  task automatic t_word();
    run(OP_WORD_ADD_IMMEDIATE, 16'h7fff, 8'h00, 8'h01, 8'h20, 16'h8000, 8'h2c);
    run(OP_WORD_ADD_IMMEDIATE, 16'hffff, 8'h00, 8'h01, 8'h20, 16'h0000, 8'h23);
    run(OP_WORD_MINUS_IMMEDIATE, 16'h0000, 8'h00, 8'h01, 8'h20, 16'hffff, 8'h35);
    run(OP_WORD_MINUS_IMMEDIATE, 16'h8000, 8'h00, 8'h01, 8'h20, 16'h7fff, 8'h38);
    $display("word test done");
  endtask : t_word

  // carry and half carry preset high to prove they survive; set all ones presets zero, overflow and half carry instead
  task automatic t_logic();
    run(OP_AND, 16'h00f0, 8'h0f, 8'hff, 8'h29, 16'h0000, 8'h23);
    run(OP_CONJUNCTION_IMMEDIATE, 16'h00f0, 8'h00, 8'hc0, 8'h29, 16'h00c0, 8'h35);
    run(OP_OR, 16'h0080, 8'h01, 8'h00, 8'h29, 16'h0081, 8'h35);
    run(OP_DISJUNCTION_IMMEDIATE, 16'h0000, 8'hff, 8'h00, 8'h29, 16'h0000, 8'h23);
    run(OP_EXCLUSIVE_DISJUNCTION, 16'h00a5, 8'h0f, 8'h00, 8'h29, 16'h00aa, 8'h35);
    run(OP_BIT_SET_MASK, 16'h0001, 8'h00, 8'h80, 8'h29, 16'h0081, 8'h35);
    run(OP_BIT_CLEAR_MASK, 16'h00ff, 8'h00, 8'h0f, 8'h29, 16'h00f0, 8'h35);
    run(OP_SELF_AND_CHECK, 16'h0080, 8'h00, 8'h00, 8'h29, 16'h0080, 8'h35);
    run(OP_ZERO_REGISTER, 16'h0055, 8'h00, 8'h00, 8'h29, 16'h0000, 8'h23);
    run(OP_ALL_ONES_REGISTER, 16'h0000, 8'h00, 8'h00, 8'h2a, 16'h00ff, 8'h2a);
    $display("logic test done");
  endtask : t_logic

  task automatic t_unary();
    run(OP_PLUS_ONE, 16'h007f, 8'h00, 8'h00, 8'h21, 16'h0080, 8'h2d);
    run(OP_PLUS_ONE, 16'h00ff, 8'h00, 8'h00, 8'h20, 16'h0000, 8'h22);
    run(OP_MINUS_ONE, 16'h0080, 8'h00, 8'h00, 8'h21, 16'h007f, 8'h39);
    run(OP_INVERT_ALL_BITS, 16'h0000, 8'h00, 8'h00, 8'h28, 16'h00ff, 8'h35);
    run(OP_INVERT_ALL_BITS, 16'h00ff, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h03);
    run(OP_TWOS_MINUS, 16'h0080, 8'h00, 8'h00, 8'h20, 16'h0080, 8'h0d);
    run(OP_TWOS_MINUS, 16'h0001, 8'h00, 8'h00, 8'h00, 16'h00ff, 8'h35);
    run(OP_TWOS_MINUS, 16'h0000, 8'h00, 8'h00, 8'h01, 16'h0000, 8'h02);
    $display("unary test done");
  endtask : t_unary

  // other flags preset high: only zero and carry may move
  task automatic t_mul();
    run(OP_PRODUCT_UNSIGNED, 16'h00ff, 8'hff, 8'h00, 8'h3c, 16'hfe01, 8'h3d);
    run(OP_PRODUCT_UNSIGNED, 16'h0000, 8'h55, 8'h00, 8'h3d, 16'h0000, 8'h3e);
    run(OP_PRODUCT_SIGNED, 16'h00ff, 8'hff, 8'h00, 8'h3d, 16'h0001, 8'h3c);
    run(OP_PRODUCT_MIXED_SIGN, 16'h00ff, 8'hff, 8'h00, 8'h3c, 16'hff01, 8'h3d);
    run(OP_PRODUCT_MIXED_SIGN, 16'h0002, 8'h80, 8'h00, 8'h3d, 16'h0100, 8'h3c);
    $display("multiply test done");
  endtask : t_mul

  // result registers are read-only; the last offset reads zero
  task automatic t_regs();
    reg_wr_t(REG_FLAGS, 8'hc5);
    reg_rd_chk(REG_FLAGS, 8'hc5);
    reg_wr_t(REG_RES_LO, 8'haa);
    reg_rd_chk(REG_RES_LO, 8'h00);
    reg_rd_chk(REG_RES_HI, 8'h01);
    reg_rd_chk(2'h3, 8'h00);
    $display("register test done");
  endtask : t_regs

  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_arith();
    t_word();
    t_logic();
    t_unary();
    t_mul();
    t_regs();
    test_done();
  end
endmodule : bwalu_core_tb_top

// >>> verif/bwalu_dec_model.sv
// decoder and register file stand-in that issues operations
`timescale 1ns/10ps
module bwalu_dec_model
  import bwalu_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  op_ready_q,
  output logic       op_valid,
  output bwalu_op_e  op_code,
  output logic [7:0] dst_lo,
  output logic [7:0] dst_hi,
  output logic [7:0] source_reg,
  output logic [7:0] imm
);
  initial begin
    op_valid = 1'b0;
    op_code = OP_ADD;
    dst_lo = 8'h00;
    dst_hi = 8'h00;
    source_reg = 8'h00;
    imm = 8'h00;
  end

  // called just after a rising edge; holds until taken
  // operands scrambled after release so stale values never match
  task automatic issue(input bwalu_op_e op, input logic [7:0] lo, hi, s, k,
                       output bit taken);
    int n = 0;
    op_valid <= 1'b1;
    op_code <= op;
    dst_lo <= lo;
    dst_hi <= hi;
    source_reg <= s;
    imm <= k;
    @(posedge core_clk);
    while (op_ready_q !== 1'b1 && n < 20) begin
      n++;
      @(posedge core_clk);
    end
    taken = (op_ready_q === 1'b1);
    op_valid <= 1'b0;
    dst_lo <= ~lo;
    dst_hi <= ~hi;
    source_reg <= ~s;
    imm <= ~k;
  endtask : issue
endmodule : bwalu_dec_model
